// ===== rtl/mfg_defines.svh
// Purpose: Constants for the multifunction pin control block
// Assumes: 10 MHz clock, APB with 32-bit data
// Notes: Register indices map to byte address index * 4
`ifndef MFG_DEFINES_SVH
`define MFG_DEFINES_SVH

`define MFG_CLK_HZ 10_000_000
`define MFG_ADDR_W 18
// Register indices; byte address is four times the index
`define MFG_IDX_CTRL 16'h4043
`define MFG_IDX_DATA 16'h4080
`define MFG_IDX_IRQ_STAT 16'h4081
`define MFG_IDX_IRQ_MASK 16'h4082
// Control register reset value and writable bits
`define MFG_CTRL_RESET 16'hA400
`define MFG_CTRL_WMASK 16'hFE8F
// Pull field codes
`define MFG_PULL_NONE 2'h0
`define MFG_PULL_DOWN 2'h1
`define MFG_PULL_UP 2'h2
// Function codes with the long qualification period on input
`define MFG_FN_IN_LONG0 4'h0
`define MFG_FN_IN_LONG1 4'h4
`define MFG_FN_IN_LONG2 4'hE
`define MFG_FN_IN_LONG3 4'hF
// Debounce times in microseconds
`define MFG_DEB_SHORT_US 1000
`define MFG_DEB_LONG_US 30000
// External power clock frequency
`define MFG_EXT_CLK_HZ 2_000_000
// Interrupt status bit for a pin edge
`define MFG_IRQ_EDGE_BIT 0

`endif

// ===== rtl/mfg_pkg.sv
// Purpose: Types shared by the multifunction pin control block
// Assumes: Field layout as held in the control register
// Notes: Nothing here is imported; use mfg_pkg::name
package mfg_pkg;

    typedef struct packed {
        logic pin_direction;
        logic [1:0] pull_select;
        logic irq_edge_mode;
        logic pad_supply_select;
        logic pin_polarity;
        logic open_drain_select;
        logic rsvd8;
        logic pin_enable;
        logic [2:0] rsvd6_4;
        logic [3:0] pin_function_select;
    } mfg_ctrl_t;

    // Internal sources that may be routed out of the pin
    typedef struct packed {
        logic osc_32k;
        logic on_state;
        logic sleep_state;
        logic pwr_change;
        logic dvs1_done;
        logic dvs2_done;
        logic ext_pwr_en1;
        logic ext_pwr_en2;
        logic system_supply_good;
        logic converter_power_good;
        logic aux_reset;
    } mfg_out_src_t;

    // Pad controls going to the analogue cell
    typedef struct packed {
        logic pull_up_en;
        logic pull_down_en;
        logic supply_alt;
    } mfg_pad_cfg_t;

endpackage : mfg_pkg

// ===== rtl/mfg_debounce.sv
// Purpose: Qualifies a synchronised pin level over a selectable period
// Assumes: Input already passed a two-stage synchroniser
// Notes: A change must hold for the whole period to be accepted
`timescale 1ns/10ps
module mfg_debounce #(
    parameter int unsigned SHORT_CYC = 10000,
    parameter int unsigned LONG_CYC = 300000,
    parameter int unsigned CW = $clog2(LONG_CYC + 1)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic level_in,
    input wire logic long_sel,
    output logic level_q
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] limit;

    assign limit = long_sel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end
        else if (level_in == level_q)
        begin
            // A bounce restarts the qualification
            cnt_q <= '0;
        end
        else if (cnt_q >= limit)
        begin
            level_q <= level_in;
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : mfg_debounce

// ===== rtl/mfg_out_sel.sv
// Purpose: Picks the internal source that drives the pin as an output
// Assumes: Sources are levels on the block clock
// Notes: Reserved codes give a low level
`timescale 1ns/10ps
module mfg_out_sel (
    input wire logic [3:0] fn,
    input wire logic reg_level,
    input wire logic ext_clk,
    input wire mfg_pkg::mfg_out_src_t src,
    output logic level
);
    always_comb
    begin
        unique case (fn)
            4'h0: level = reg_level;
            4'h1: level = src.osc_32k;
            4'h2: level = src.on_state;
            4'h3: level = src.sleep_state;
            4'h4: level = src.pwr_change;
            4'h5, 4'h6, 4'h7: level = 1'b0;
            4'h8: level = src.dvs1_done;
            4'h9: level = src.dvs2_done;
            4'hA: level = src.ext_pwr_en1;
            4'hB: level = src.ext_pwr_en2;
            4'hC: level = src.system_supply_good;
            4'hD: level = src.converter_power_good;
            4'hE: level = ext_clk;
            4'hF: level = src.aux_reset;
        endcase
    end
endmodule : mfg_out_sel

// ===== rtl/mfg_pin_ctrl.sv
// Purpose: Control register and pin logic for one multifunction pin
// Assumes: APB slave, 10 MHz clock, synchronous active-high reset
// Notes: Function codes are meant for internal request blocks
`timescale 1ns/10ps
`include "mfg_defines.svh"
module mfg_pin_ctrl #(
    parameter int unsigned DEB_SHORT_CYC =
        `MFG_DEB_SHORT_US * (`MFG_CLK_HZ / 1_000_000),
    parameter int unsigned DEB_LONG_CYC =
        `MFG_DEB_LONG_US * (`MFG_CLK_HZ / 1_000_000)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MFG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output mfg_pkg::mfg_pad_cfg_t pad_cfg,
    input wire mfg_pkg::mfg_out_src_t out_src,
    output logic [15:0] in_func,
    output logic irq
);
    localparam int unsigned EXT_DIV = `MFG_CLK_HZ / `MFG_EXT_CLK_HZ;
    localparam logic [`MFG_ADDR_W-1:0] ADDR_CTRL =
        `MFG_ADDR_W'({`MFG_IDX_CTRL, 2'b00});
    localparam logic [`MFG_ADDR_W-1:0] ADDR_DATA =
        `MFG_ADDR_W'({`MFG_IDX_DATA, 2'b00});
    localparam logic [`MFG_ADDR_W-1:0] ADDR_STAT =
        `MFG_ADDR_W'({`MFG_IDX_IRQ_STAT, 2'b00});
    localparam logic [`MFG_ADDR_W-1:0] ADDR_MASK =
        `MFG_ADDR_W'({`MFG_IDX_IRQ_MASK, 2'b00});

    // Long qualification codes, valid only for the input table
    function automatic logic is_long_fn(input logic [3:0] fn);
        is_long_fn = (fn == `MFG_FN_IN_LONG0) || (fn == `MFG_FN_IN_LONG1) ||
            (fn == `MFG_FN_IN_LONG2) || (fn == `MFG_FN_IN_LONG3);
    endfunction : is_long_fn

    function automatic logic addr_known(input logic [`MFG_ADDR_W-1:0] a);
        addr_known = (a == ADDR_CTRL) || (a == ADDR_DATA) ||
            (a == ADDR_STAT) || (a == ADDR_MASK);
    endfunction : addr_known

    mfg_pkg::mfg_ctrl_t ctrl_q;
    logic out_level_q;
    logic irq_stat_q;
    logic irq_mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic pad_sync1_q;
    logic pad_sync2_q;
    logic osc_sync1_q;
    logic osc_sync2_q;
    logic deb_level;
    logic deb_prev_q;
    logic [$clog2(EXT_DIV)-1:0] ext_cnt_q;
    logic ext_clk_q;
    logic pad_out_q;
    logic pad_oe_q;
    mfg_pkg::mfg_pad_cfg_t pad_cfg_q;
    logic [15:0] in_func_q;
    logic irq_q;
    logic sel_level;
    logic drive_level;
    logic act_level;
    logic act_prev;
    logic edge_evt;
    logic is_input;
    logic setup_ph;
    logic wr_acc;
    mfg_pkg::mfg_out_src_t src_sync;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite;
    assign is_input = ctrl_q.pin_direction;

    // Pad and oscillator are outside this clock domain
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pad_sync1_q <= 1'b0;
            pad_sync2_q <= 1'b0;
            osc_sync1_q <= 1'b0;
            osc_sync2_q <= 1'b0;
        end
        else
        begin
            pad_sync1_q <= pad_in;
            pad_sync2_q <= pad_sync1_q;
            osc_sync1_q <= out_src.osc_32k;
            osc_sync2_q <= osc_sync1_q;
        end
    end

    mfg_debounce #(
        .SHORT_CYC(DEB_SHORT_CYC),
        .LONG_CYC(DEB_LONG_CYC)
    ) u_deb (
        .clk(clk),
        .srst(srst),
        .level_in(pad_sync2_q),
        .long_sel(is_input && is_long_fn(ctrl_q.pin_function_select)),
        .level_q(deb_level)
    );

    // Register accesses
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q <= `MFG_CTRL_RESET;
            out_level_q <= 1'b0;
            irq_mask_q <= 1'b0;
        end
        else if (wr_acc)
        begin
            if (paddr == ADDR_CTRL)
            begin
                ctrl_q <= pwdata[15:0] & `MFG_CTRL_WMASK;
            end
            if (paddr == ADDR_DATA)
            begin
                out_level_q <= pwdata[0];
            end
            if (paddr == ADDR_MASK)
            begin
                irq_mask_q <= pwdata[`MFG_IRQ_EDGE_BIT];
            end
        end
    end

    // No wait states: data and ready are set up in the setup cycle
    // Unmapped reads return zero so no stale word leaks out
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else if (setup_ph)
        begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_known(paddr);
            prdata_q <= 32'h0000_0000;
            if (!pwrite)
            begin
                unique case (paddr)
                    ADDR_CTRL: prdata_q <= {16'h0000, ctrl_q};
                    ADDR_DATA: prdata_q <= {29'h0000_0000, act_level,
                        deb_level, out_level_q};
                    ADDR_STAT: prdata_q <= {31'h0000_0000, irq_stat_q};
                    ADDR_MASK: prdata_q <= {31'h0000_0000, irq_mask_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
        else if (pready_q)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // Logical level follows polarity; low-active pins read inverted
    assign act_level = ctrl_q.pin_polarity ? deb_level : !deb_level;
    assign act_prev = ctrl_q.pin_polarity ? deb_prev_q : !deb_prev_q;

    always_comb
    begin
        // Both-edge mode ignores polarity, so it watches the raw level
        if (ctrl_q.irq_edge_mode)
        begin
            edge_evt = deb_level != deb_prev_q;
        end
        else
        begin
            edge_evt = act_level && !act_prev;
        end
    end

    // A new edge wins over a write-one clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            deb_prev_q <= 1'b0;
            irq_stat_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            deb_prev_q <= deb_level;
            if (edge_evt)
            begin
                irq_stat_q <= 1'b1;
            end
            else if (wr_acc && paddr == ADDR_STAT && pwdata[`MFG_IRQ_EDGE_BIT])
            begin
                irq_stat_q <= 1'b0;
            end
            irq_q <= irq_stat_q && irq_mask_q;
        end
    end

    assign irq = irq_q;

    // External power clock divider, low for the odd extra cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ext_cnt_q <= '0;
            ext_clk_q <= 1'b0;
        end
        else
        begin
            if (ext_cnt_q == ($clog2(EXT_DIV))'(EXT_DIV - 1))
            begin
                ext_cnt_q <= '0;
            end
            else
            begin
                ext_cnt_q <= ext_cnt_q + 1'b1;
            end
            ext_clk_q <= ext_cnt_q < ($clog2(EXT_DIV))'(EXT_DIV / 2);
        end
    end

    always_comb
    begin
        src_sync = out_src;
        src_sync.osc_32k = osc_sync2_q;
    end

    mfg_out_sel u_sel (
        .fn(ctrl_q.pin_function_select),
        .reg_level(out_level_q),
        .ext_clk(ext_clk_q),
        .src(src_sync),
        .level(sel_level)
    );

    // Output table applies only with direction set to output
    assign drive_level = ctrl_q.pin_polarity ? sel_level : !sel_level;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
        end
        else if (!ctrl_q.pin_enable || is_input)
        begin
            // Tri-stated when disabled or used as an input
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
        end
        else if (ctrl_q.open_drain_select)
        begin
            // Open drain only sinks; a high is left to the pull-up
            pad_out_q <= 1'b0;
            pad_oe_q <= !drive_level;
        end
        else
        begin
            pad_out_q <= drive_level;
            pad_oe_q <= 1'b1;
        end
    end

    assign pad_out = pad_out_q;
    assign pad_oe = pad_oe_q;

    // Reserved pull code leaves both resistors off
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            // Matches the pull-down reset value so the pad never floats at start
            pad_cfg_q.pull_up_en <= 1'b0;
            pad_cfg_q.pull_down_en <= 1'b1;
            pad_cfg_q.supply_alt <= 1'b0;
        end
        else
        begin
            pad_cfg_q.pull_up_en <= ctrl_q.pull_select == `MFG_PULL_UP;
            pad_cfg_q.pull_down_en <= ctrl_q.pull_select == `MFG_PULL_DOWN;
            pad_cfg_q.supply_alt <= ctrl_q.pad_supply_select;
        end
    end

    assign pad_cfg = pad_cfg_q;

    // Input table: one request line per function code
    // Lines are levels; the request blocks do their own edge handling
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            in_func_q <= 16'h0000;
        end
        else
        begin
            for (int k = 0; k < 16; k++)
            begin
                in_func_q[k] <= is_input && ctrl_q.pin_enable && act_level &&
                    (ctrl_q.pin_function_select == 4'(k));
            end
        end
    end

    assign in_func = in_func_q;

endmodule : mfg_pin_ctrl

// ===== verification/mfg_pin_ctrl_props.sv
// Purpose: Port-level checks for the multifunction pin block
// Assumes: Control and data register writes seen on APB are mirrored here
// Notes: Pin checks wait one quiet cycle after a register change
`timescale 1ns/10ps
`include "mfg_defines.svh"
module mfg_pin_ctrl_props (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MFG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pad_in,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire mfg_pkg::mfg_pad_cfg_t pad_cfg,
    input wire mfg_pkg::mfg_out_src_t out_src,
    input wire logic [15:0] in_func,
    input wire logic irq
);
    logic [15:0] ctrl_q;
    logic data_q;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite;
    always_ff @(posedge clk)
    begin
        if (srst)
            ctrl_q <= `MFG_CTRL_RESET;
        else if (wr_ok && paddr == {`MFG_IDX_CTRL, 2'b00})
            ctrl_q <= pwdata[15:0] & `MFG_CTRL_WMASK;
    end
    always_ff @(posedge clk)
    begin
        if (srst)
            data_q <= 1'b0;
        else if (wr_ok && paddr == {`MFG_IDX_DATA, 2'b00})
            data_q <= pwdata[0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; pready ##1 !pready; endsequence
    // Outputs lag a register write by one cycle, so only settled settings are judged
    sequence s_quiet; $stable(ctrl_q) && $stable(data_q); endsequence
    a_ready_pulse: assert property (s_setup |=> s_answer)
        else $error("pready not a single cycle after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_pull_map: assert property (s_quiet |-> pad_cfg.pull_up_en == (ctrl_q[14:13] == 2'h2)
        && pad_cfg.pull_down_en == (ctrl_q[14:13] == 2'h1)) else $error("pull enables wrong");
    a_supply_sel: assert property (s_quiet |-> pad_cfg.supply_alt == ctrl_q[11])
        else $error("supply select wrong");
    a_pin_tristate: assert property (s_quiet ##0 (!ctrl_q[7] || ctrl_q[15]) |-> !pad_oe)
        else $error("pin driven while off or input");
    a_push_pull: assert property (s_quiet ##0 (ctrl_q & 16'h8280) == 16'h0080 |-> pad_oe)
        else $error("push-pull output not driven");
    a_reg_level: assert property (s_quiet ##0 (ctrl_q & 16'h828F) == 16'h0080
        |-> pad_out == (data_q ^ !ctrl_q[10])) else $error("register level wrong");
    a_open_drain: assert property (s_quiet ##0 (ctrl_q & 16'h828F) == 16'h0280
        |-> !pad_out && pad_oe == !(data_q ^ !ctrl_q[10])) else $error("open drain wrong");
    a_func_code: assert property (s_quiet ##0 in_func != 16'h0000
        |-> in_func == 16'h0001 << ctrl_q[3:0]) else $error("input function wrong");
    a_func_off: assert property (s_quiet ##0 (!ctrl_q[15] || !ctrl_q[7])
        |-> in_func == 16'h0000) else $error("input function while off");
endmodule : mfg_pin_ctrl_props

// ===== verification/mfg_board_pin.sv
// Purpose: Board wire attached to the pin
// Assumes: Testbench drives the far side only when the block does not
// Notes: An undriven, unpulled wire flips each cycle to expose stale reads
`timescale 1ns/10ps
module mfg_board_pin (
    input wire logic clk,
    input wire logic ext_en,
    input wire logic ext_level,
    input wire logic pad_out,
    input wire logic pad_oe,
    input wire mfg_pkg::mfg_pad_cfg_t pad_cfg,
    output logic pad_in
);
    logic last_q = 1'b0;
    always @(posedge clk)
        last_q <= pad_in;
    always_comb
    begin
        if (pad_oe)
            pad_in = pad_out;
        else if (ext_en)
            pad_in = ext_level;
        else if (pad_cfg.pull_up_en)
            pad_in = 1'b1;
        else if (pad_cfg.pull_down_en)
            pad_in = 1'b0;
        else
            pad_in = ~last_q;
    end
endmodule : mfg_board_pin

// ===== verification/mfg_pin_ctrl_tb.sv
// Purpose: Self-checking bench for the multifunction pin block
// Assumes: Short debounce counts of 4 and 8 cycles
// Notes: Outputs are sampled at the falling edge, after updates land
`timescale 1ns/10ps
`include "mfg_defines.svh"
module mfg_pin_ctrl_tb;
    localparam logic [17:0] A_CTRL = {`MFG_IDX_CTRL, 2'b00};
    localparam logic [17:0] A_DATA = {`MFG_IDX_DATA, 2'b00};
    localparam logic [17:0] A_STAT = {`MFG_IDX_IRQ_STAT, 2'b00};
    localparam logic [17:0] A_MASK = {`MFG_IDX_IRQ_MASK, 2'b00};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pad_in;
    logic pad_out;
    logic pad_oe;
    logic ext_en = 1'b0;
    logic ext_level = 1'b0;
    mfg_pkg::mfg_pad_cfg_t pad_cfg;
    mfg_pkg::mfg_out_src_t out_src = 11'h000;
    logic [15:0] in_func;
    logic irq;
    logic [31:0] rd;
    logic er;
    logic [15:0] r;
    logic md, pol, dir, lv;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 59;
    int hi;
    always #50 clk = ~clk;
    mfg_pin_ctrl #(.DEB_SHORT_CYC(4), .DEB_LONG_CYC(8)) mfg_pin_ctrl_i (.clk(clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_cfg(pad_cfg), .out_src(out_src),
        .in_func(in_func), .irq(irq));
    mfg_board_pin mfg_board_pin_i (.clk(clk), .ext_en(ext_en), .ext_level(ext_level),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_cfg(pad_cfg), .pad_in(pad_in));
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Holds the request until pready is sampled high, then releases it
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rchk(input string name, input logic [17:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, rd, exp);
    endtask : rchk
    task settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle
    function automatic logic exp_src(input int f, input mfg_pkg::mfg_out_src_t s);
        logic [15:0] v;
        v = {s.aux_reset, 1'b0, s.converter_power_good, s.system_supply_good, s.ext_pwr_en2,
            s.ext_pwr_en1, s.dvs2_done, s.dvs1_done, 3'h0, s.pwr_change, s.sleep_state,
            s.on_state, s.osc_32k, 1'b0};
        return v[f];
    endfunction : exp_src
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rchk("ctrl_reset", A_CTRL, 32'h0000_A400);
        check("cfg_reset", 32'(pad_cfg), 32'h0000_0002);
        check("oe_reset", 32'(pad_oe), 32'h0000_0000);
        apb(1'b0, 18'h0_0100, 32'h0000_0000);
        check("unmapped", {31'h0, er}, 32'h0000_0001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            r = 16'($random(seed));
            r[14:13] = i[1:0];
            apb(1'b1, A_CTRL, 32'(r));
            rchk("ctrl_rw", A_CTRL, 32'(r & `MFG_CTRL_WMASK));
            settle(1);
            check("pull_up", 32'(pad_cfg.pull_up_en), 32'(r[14:13] == 2'h2));
            check("pull_dn", 32'(pad_cfg.pull_down_en), 32'(r[14:13] == 2'h1));
            check("supply", 32'(pad_cfg.supply_alt), 32'(r[11]));
            if (!r[7] || r[15])
                check("tristate", 32'(pad_oe), 32'h0000_0000);
        end
        $display("test config done");
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, A_DATA, 32'(k[0]));
            apb(1'b1, A_CTRL, 32'h0000_0080 | 32'(k[1]) << 10 | 32'(k[2]) << 9);
            settle(2);
            lv = k[0] ^ !k[1];
            check("reg_out", 32'(pad_out), 32'(k[2] ? 1'b0 : lv));
            check("reg_oe", 32'(pad_oe), 32'(k[2] ? !lv : 1'b1));
        end
        for (int i = 0; i < 30; i++)
        begin
            if (i % 15 + 1 == 14)
                continue;
            @(posedge clk);
            out_src <= 11'($random(seed));
            apb(1'b1, A_CTRL, 32'h0000_0480 | 32'(i % 15 + 1));
            settle(4);
            check("src_out", 32'(pad_out), 32'(exp_src(i % 15 + 1, out_src)));
        end
        apb(1'b1, A_CTRL, 32'h0000_048E);
        settle(3);
        hi = 0;
        repeat (10)
        begin
            @(negedge clk);
            if (pad_out === 1'b1)
                hi++;
        end
        check("clk_high", 32'(hi), 32'h0000_0004);
        $display("test output done");
        @(posedge clk);
        ext_en <= 1'b1;
        for (int f = 0; f < 16; f++)
        begin
            apb(1'b1, A_CTRL, 32'h0000_8480 | 32'(f));
            // Let the pin settle low first, whatever an earlier test left behind
            settle(12);
            @(posedge clk);
            ext_level <= 1'b1;
            settle(9);
            check("in_fast", 32'(in_func[f]), 32'(!(f inside {0, 4, 14, 15})));
            settle(8);
            check("in_code", 32'(in_func), 32'(16'h0001 << f));
            @(posedge clk);
            ext_level <= 1'b0;
            settle(17);
            check("in_idle", 32'(in_func), 32'h0000_0000);
        end
        $display("test input done");
        for (int k = 0; k < 8; k++)
        begin
            {md, pol, dir} = k[2:0];
            @(posedge clk);
            ext_level <= !dir;
            apb(1'b1, A_CTRL, 32'h0000_8081 | 32'(md) << 12 | 32'(pol) << 10);
            apb(1'b1, A_MASK, 32'(k % 3 != 0));
            settle(20);
            apb(1'b1, A_STAT, 32'h0000_0001);
            rchk("stat_clr", A_STAT, 32'h0000_0000);
            settle(1);
            check("irq_clr", 32'(irq), 32'h0000_0000);
            @(posedge clk);
            ext_level <= dir;
            settle(20);
            rchk("stat_edge", A_STAT, 32'(md | (dir == pol)));
            check("irq", 32'(irq), 32'(k % 3 != 0 && (md | (dir == pol))));
        end
        $display("test irq done");
        finish_test();
    end
endmodule : mfg_pin_ctrl_tb
bind mfg_pin_ctrl mfg_pin_ctrl_props mfg_pin_ctrl_props_i (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_cfg(pad_cfg), .out_src(out_src), .in_func(in_func), .irq(irq));
